// ---- logic/pst_top.sv ----
// Self-test generator, analyser, coder and loopback paths of a line unit
`timescale 1ns/1ns
`default_nettype none
module pst_top #(
  parameter int BIT_DIV = pst_pkg::BIT_DIV_DEF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Transmit side pins
  input wire logic tx_positive_data,
  input wire logic tx_negative_data,
  input wire logic tx_input_clock,
  // Line side pins
  input wire logic line_in_a,
  input wire logic line_in_b,
  output logic line_out_pos,
  output logic line_out_neg,
  // Test and mode controls, active low except coder_enable_n, which turns the coder on when high
  input wire logic seq_inject_n,
  input wire logic internal_loop_n,
  input wire logic line_out_disable_n,
  input wire logic terminal_loop_n,
  input wire logic line_loop_n,
  input wire logic coder_enable_n,
  // Receive side pins
  output logic rx_positive_data,
  output logic rx_negative_data,
  output logic recovered_clock_out,
  output logic selftest_pass,
  // Register port
  input wire logic [pst_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pst_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pst_pkg::DATA_W-1:0] reg_rdata,
  output logic irq
);
  initial begin
    if (BIT_DIV < 2 || BIT_DIV > 255) $error("pst_top: BIT_DIV out of range");
  end

  localparam logic [7:0] DIV_LAST = 8'(BIT_DIV - 1);
  localparam logic [7:0] DIV_HALF = 8'(BIT_DIV / 2);

  logic rst_meta_q;
  logic rst_n;
  logic [pst_pkg::PIN_W-1:0] pins;
  logic [pst_pkg::PIN_W-1:0] sy1_q;
  logic [pst_pkg::PIN_W-1:0] sy2_q;
  logic [pst_pkg::PIN_W-1:0] sy3_q;
  logic [pst_pkg::PIN_W-1:0] pin_q;
  logic [pst_pkg::PIN_W-1:0] agree;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Pins are asynchronous; accept a level only once stages two and three agree
  assign pins = {coder_enable_n, line_loop_n, terminal_loop_n,
                 line_out_disable_n, internal_loop_n, seq_inject_n,
                 line_in_b, line_in_a, tx_input_clock,
                 tx_negative_data, tx_positive_data};
  assign agree = ~(sy2_q ^ sy3_q);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_q <= pst_pkg::PIN_RST;
      sy2_q <= pst_pkg::PIN_RST;
      sy3_q <= pst_pkg::PIN_RST;
      pin_q <= pst_pkg::PIN_RST;
    end else begin
      sy1_q <= pins;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      pin_q <= (pin_q & ~agree) | (sy3_q & agree);
    end
  end

  // Decoded controls, true when the mode is active
  logic inj_on, iloop_on, ldis_on, tloop_on, lloop_on, coder_on;
  assign inj_on = !pin_q[pst_pkg::P_INJ];
  assign iloop_on = !pin_q[pst_pkg::P_ILOOP];
  assign ldis_on = !pin_q[pst_pkg::P_LDIS];
  assign tloop_on = !pin_q[pst_pkg::P_TLOOP];
  assign lloop_on = !pin_q[pst_pkg::P_LLOOP];
  assign coder_on = pin_q[pst_pkg::P_CODER];

  // Bit slot timing; recovered clock high in the first half of a slot
  logic [7:0] div_q;
  logic tick;
  assign tick = (div_q == DIV_LAST);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) div_q <= 8'h00;
    else div_q <= tick ? 8'h00 : div_q + 8'h01;
  end

  // Sequence generator and analyser
  logic prbs_bit;
  logic an_pass;
  logic [4:0] an_run;
  logic rx_bit;

  pst_prbs_gen u_gen (
    .clk(ref_clk),
    .rst_n(rst_n),
    .step(tick),
    .bit_out(prbs_bit)
  );

  // Watches the receive bit that drives rx_positive_data outside terminal loop, own or outside sequence
  pst_prbs_chk u_chk (
    .clk(ref_clk),
    .rst_n(rst_n),
    .step(tick),
    .bit_in(rx_bit),
    .pass(an_pass),
    .run(an_run)
  );

  // Receive state declared early; the transmit source reads it
  pst_pkg::pst_sym_t rin_q;
  logic [2:0] dec_q;
  logic rlast_pos_q;

  // Transmit source: line loop, then injection, then pins
  logic src_p, src_n;
  assign src_p = lloop_on ? rx_bit :
                 inj_on ? prbs_bit : pin_q[pst_pkg::P_TXP];
  assign src_n = lloop_on ? (!coder_on && rin_q == pst_pkg::SYM_NEG) :
                 inj_on ? 1'b0 : pin_q[pst_pkg::P_TXN];

  // Zero-substitution encoder with three-slot lookahead
  pst_pkg::pst_sym_t enc0_q, enc1_q, enc2_q, new_sym, bsym;
  logic [1:0] zrun_q;
  logic last_pos_q, odd_q, zsub, sub_even, pulse_pos;

  assign zsub = coder_on && !src_p && (zrun_q == 2'h2);
  assign sub_even = zsub && !odd_q;
  // Violation copies last pulse if odd, else follows an inserted opposite B
  assign pulse_pos = zsub ? (odd_q ? last_pos_q : !last_pos_q) : !last_pos_q;
  assign bsym = last_pos_q ? pst_pkg::SYM_NEG : pst_pkg::SYM_POS;
  assign new_sym = !coder_on ?
                   (src_p ? pst_pkg::SYM_POS :
                    src_n ? pst_pkg::SYM_NEG : pst_pkg::SYM_ZERO) :
                   (src_p || zsub) ?
                   (pulse_pos ? pst_pkg::SYM_POS : pst_pkg::SYM_NEG) :
                   pst_pkg::SYM_ZERO;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enc0_q <= pst_pkg::SYM_ZERO;
      enc1_q <= pst_pkg::SYM_ZERO;
      enc2_q <= pst_pkg::SYM_ZERO;
      zrun_q <= 2'h0;
      last_pos_q <= 1'b0;
      odd_q <= 1'b0;
    end else if (tick) begin
      enc0_q <= new_sym;
      enc1_q <= enc0_q;
      enc2_q <= sub_even ? bsym : enc1_q;
      zrun_q <= (src_p || zsub) ? 2'h0 : zrun_q + 2'h1;
      if (src_p || zsub) last_pos_q <= pulse_pos;
      odd_q <= zsub ? 1'b0 : (src_p ? !odd_q : odd_q);
    end
  end

  // Line output; forced low while disabled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_out_pos <= 1'b0;
      line_out_neg <= 1'b0;
    end else begin
      line_out_pos <= !ldis_on && enc2_q == pst_pkg::SYM_POS;
      line_out_neg <= !ldis_on && enc2_q == pst_pkg::SYM_NEG;
    end
  end

  // Receive input: encoder output on internal loop, else line pins
  pst_pkg::pst_sym_t rx_in;
  logic rpulse, viol;
  assign rx_in = iloop_on ? enc2_q :
                 pin_q[pst_pkg::P_LINA] ? pst_pkg::SYM_POS :
                 pin_q[pst_pkg::P_LINB] ? pst_pkg::SYM_NEG :
                 pst_pkg::SYM_ZERO;
  assign rpulse = (rx_in != pst_pkg::SYM_ZERO);
  // Same polarity twice marks a substitution to be removed
  assign viol = rpulse && ((rx_in == pst_pkg::SYM_POS) == rlast_pos_q);
  assign rx_bit = coder_on ? dec_q[2] : (rin_q == pst_pkg::SYM_POS);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rin_q <= pst_pkg::SYM_ZERO;
      dec_q <= 3'h0;
      rlast_pos_q <= 1'b0;
    end else if (tick) begin
      rin_q <= rx_in;
      // V and both slots before it are cleared, B included
      dec_q <= viol ? 3'h0 : {dec_q[1:0], rpulse};
      if (rpulse) rlast_pos_q <= (rx_in == pst_pkg::SYM_POS);
    end
  end

  // Receive outputs; terminal loop passes pins and clock straight across
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_positive_data <= 1'b0;
      rx_negative_data <= 1'b0;
      recovered_clock_out <= 1'b0;
      selftest_pass <= 1'b0;
    end else begin
      selftest_pass <= an_pass;
      if (tloop_on) begin
        rx_positive_data <= pin_q[pst_pkg::P_TXP];
        rx_negative_data <= pin_q[pst_pkg::P_TXN];
        recovered_clock_out <= pin_q[pst_pkg::P_TXCLK];
      end else begin
        rx_positive_data <= rx_bit;
        rx_negative_data <= !coder_on && rin_q == pst_pkg::SYM_NEG;
        recovered_clock_out <= (div_q < DIV_HALF);
      end
    end
  end

  // Event flags, mask and register reads
  logic [pst_pkg::EV_W-1:0] status_q, mask_q, ev, clr;
  logic pass_old_q;
  logic sel_status, sel_mask, sel_state;
  logic [pst_pkg::DATA_W-1:0] rd_mux;

  assign ev = {pass_old_q && !an_pass, !pass_old_q && an_pass};
  assign sel_status = (reg_addr == pst_pkg::OFS_STATUS);
  assign sel_mask = (reg_addr == pst_pkg::OFS_MASK);
  assign sel_state = (reg_addr == pst_pkg::OFS_STATE);
  // Set wins over a write-one clear in the same cycle
  assign clr = (reg_wr && sel_status) ? reg_wdata[pst_pkg::EV_W-1:0] : '0;
  assign rd_mux = sel_status ? {6'h00, status_q} :
                  sel_mask ? {6'h00, mask_q} :
                  sel_state ? {2'h0, an_run, an_pass} : 8'h00;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
      mask_q <= '0;
      pass_old_q <= 1'b0;
      irq <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      pass_old_q <= an_pass;
      status_q <= (status_q & ~clr) | ev;
      if (reg_wr && sel_mask) mask_q <= reg_wdata[pst_pkg::EV_W-1:0];
      irq <= |(status_q & mask_q);
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Checks on the data paths
  chk_line_forced_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ldis_on |=> !line_out_pos && !line_out_neg)
    else $error("line output active while disabled");
  chk_term_loop_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tloop_on |=> rx_positive_data == $past(pin_q[pst_pkg::P_TXP]))
    else $error("terminal loop did not pass transmit data");
  chk_coder_neg_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    coder_on && !tloop_on |=> !rx_negative_data)
    else $error("negative rail active with decoder on");
  chk_inject_source: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && inj_on && !lloop_on && prbs_bit |=> enc0_q != pst_pkg::SYM_ZERO)
    else $error("sequence not injected");
  chk_line_loop_src: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && lloop_on && rx_bit |=> enc0_q != pst_pkg::SYM_ZERO)
    else $error("line loop not fed back");
  chk_subst_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && zsub |=> enc0_q != pst_pkg::SYM_ZERO)
    else $error("third zero not substituted");
  chk_int_loop_path: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && iloop_on |=> rin_q == $past(enc2_q))
    else $error("internal loop not routed to receive");
  chk_pass_output: assert property (@(posedge ref_clk) disable iff (!rst_n)
    selftest_pass |-> $past(an_run) >= pst_pkg::PASS_RUN - 5'h01)
    else $error("pass shown without a verified run");
endmodule
`default_nettype wire

// ---- logic/pst_pkg.sv ----
// Shared constants for the pseudorandom self-test and loopback block
package pst_pkg;
  // Synchronised pin vector layout
  localparam int PIN_W = 11;
  localparam int P_TXP = 0;
  localparam int P_TXN = 1;
  localparam int P_TXCLK = 2;
  localparam int P_LINA = 3;
  localparam int P_LINB = 4;
  localparam int P_INJ = 5;
  localparam int P_ILOOP = 6;
  localparam int P_LDIS = 7;
  localparam int P_TLOOP = 8;
  localparam int P_LLOOP = 9;
  localparam int P_CODER = 10;
  // Active-low controls come out of reset inactive (high)
  localparam logic [10:0] PIN_RST = 11'h7e0;
  // Register map
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_MASK = 4'h4;
  localparam logic [3:0] OFS_STATE = 4'h8;
  localparam int EV_W = 2;
  localparam int EV_PASS_UP = 0;
  localparam int EV_PASS_DOWN = 1;
  // Sequence generator and analyser
  localparam int LFSR_W = 15;
  localparam int TAP_A = 14;
  localparam int TAP_B = 13;
  localparam logic [14:0] LFSR_SEED = 15'h7fff;
  localparam logic [4:0] PASS_RUN = 5'h0f;
  localparam int BIT_DIV_DEF = 4;
  // Line symbol, {negative, positive}
  typedef enum logic [1:0] {
    SYM_ZERO = 2'h0,
    SYM_POS = 2'h1,
    SYM_NEG = 2'h2
  } pst_sym_t;
  // Analyser lock state, Gray along hunt, verify, pass
  typedef enum logic [1:0] {
    AN_HUNT = 2'h0,
    AN_VERIFY = 2'h1,
    AN_PASS = 2'h3
  } pst_an_t;
endpackage

// ---- logic/pst_prbs_gen.sv ----
// Fifteen-stage maximal-length sequence generator
`timescale 1ns/1ns
`default_nettype none
module pst_prbs_gen #(
  parameter int W = pst_pkg::LFSR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Advance one bit
  input wire logic step,
  output logic bit_out
);
  initial begin
    if (W != pst_pkg::LFSR_W) $error("pst_prbs_gen: only 15 stages");
  end

  logic [W-1:0] sr_q;
  logic fb;

  // Taps 15 and 14
  assign fb = sr_q[pst_pkg::TAP_A] ^ sr_q[pst_pkg::TAP_B];
  assign bit_out = fb;

  // Nonzero seed, otherwise the register would lock at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_q <= pst_pkg::LFSR_SEED;
    end else if (step) begin
      sr_q <= {sr_q[W-2:0], fb};
    end
  end

  chk_gen_never_zero: assert property (@(posedge clk) disable iff (!rst_n)
    sr_q != '0) else $error("generator fell into all-zero state");
endmodule
`default_nettype wire

// ---- logic/pst_prbs_chk.sv ----
// Self-synchronising sequence analyser with pass flag
`timescale 1ns/1ns
`default_nettype none
module pst_prbs_chk #(
  parameter int W = pst_pkg::LFSR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Received bit stream
  input wire logic step,
  input wire logic bit_in,
  // Verdict
  output logic pass,
  output logic [4:0] run
);
  initial begin
    if (W != pst_pkg::LFSR_W) $error("pst_prbs_chk: only 15 stages");
  end

  logic [W-1:0] sr_q;
  logic [4:0] run_q;
  pst_pkg::pst_an_t st_q;
  pst_pkg::pst_an_t st_d;
  logic predict;
  logic match;

  // Prediction from the bits already seen; they are reloaded each step
  assign predict = sr_q[pst_pkg::TAP_A] ^ sr_q[pst_pkg::TAP_B];
  assign match = (bit_in == predict) && (sr_q != '0);
  assign pass = (st_q == pst_pkg::AN_PASS);
  assign run = run_q;

  // Lock progression; any mismatch falls back to hunting
  always_comb begin
    st_d = st_q;
    case (st_q)
      pst_pkg::AN_HUNT: begin
        if (step && match) st_d = pst_pkg::AN_VERIFY;
      end
      pst_pkg::AN_VERIFY: begin
        if (step && !match) st_d = pst_pkg::AN_HUNT;
        else if (step && run_q == pst_pkg::PASS_RUN - 5'h01)
          st_d = pst_pkg::AN_PASS;
      end
      pst_pkg::AN_PASS: begin
        if (step && !match) st_d = pst_pkg::AN_HUNT;
      end
      default: st_d = pst_pkg::AN_HUNT;
    endcase
  end

  // Shift register fills from the line itself
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_q <= '0;
      run_q <= '0;
      st_q <= pst_pkg::AN_HUNT;
    end else begin
      st_q <= st_d;
      if (step) begin
        sr_q <= {sr_q[W-2:0], bit_in};
        if (!match) run_q <= '0;
        else if (run_q != pst_pkg::PASS_RUN) run_q <= run_q + 5'h01;
      end
    end
  end

  chk_pass_needs_run: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pass) |-> $past(run_q) == pst_pkg::PASS_RUN - 5'h01)
    else $error("pass raised before fifteen agreeing bits");
  chk_mismatch_drops_pass: assert property (@(posedge clk)
    disable iff (!rst_n) step && !match |=> !pass && run_q == '0)
    else $error("pass survived a mismatch");
endmodule
`default_nettype wire

// ---- testbench/pst_test_ctl.sv ----
// Board test controller: mode pins and an optional line loop capacitor
`timescale 1ns/1ns
`default_nettype none
module pst_test_ctl (
  // Clock
  input wire logic clk,
  // Line outputs of the unit
  input wire logic line_out_pos,
  input wire logic line_out_neg,
  // Mode pins, active low except coder_enable_n, which turns the coder on when high
  output logic seq_inject_n,
  output logic internal_loop_n,
  output logic line_out_disable_n,
  output logic terminal_loop_n,
  output logic line_loop_n,
  output logic coder_enable_n,
  // Line inputs of the unit
  output logic line_in_a,
  output logic line_in_b
);
  // Mode {coder, line loop, term loop, disable, int loop, inject}
  logic [5:0] mode_q = 6'h3f;
  logic ext_q = 1'b0;
  logic [1:0] lvl_q = 2'h0;

  // Changes land just after an edge, like any board controller
  task automatic set_mode(input logic [5:0] m, input logic e,
                          input logic [1:0] l);
    @(posedge clk);
    mode_q <= m;
    ext_q <= e;
    lvl_q <= l;
  endtask

  // Other loops stay off while the internal loop runs
  assign terminal_loop_n = mode_q[3] | ~mode_q[1];
  assign line_loop_n = mode_q[4] | ~mode_q[1];
  assign seq_inject_n = mode_q[0];
  assign internal_loop_n = mode_q[1];
  assign line_out_disable_n = mode_q[2];
  assign coder_enable_n = mode_q[5];
  // Capacitor loop, else a fixed level standing in for a far line
  assign line_in_a = ext_q ? line_out_pos : lvl_q[0];
  assign line_in_b = ext_q ? line_out_neg : lvl_q[1];
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the self-test and loopback block
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int DIV = 4;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic tx_positive_data = 1'b0;
  logic tx_negative_data = 1'b0;
  logic tx_input_clock = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tx_rand = 1'b0;
  wire logic line_out_pos, line_out_neg, rx_positive_data, rx_negative_data;
  wire logic recovered_clock_out, selftest_pass, irq, line_in_a, line_in_b;
  wire logic seq_inject_n, internal_loop_n, line_out_disable_n;
  wire logic terminal_loop_n, line_loop_n, coder_enable_n;
  wire logic [7:0] reg_rdata;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  logic [7:0] rd;
  logic [3:0] seen;
  logic [2:0] v;

  pst_top #(.BIT_DIV(DIV)) i_pst_top (.ref_clk(ref_clk), .resetn(resetn),
    .tx_positive_data(tx_positive_data), .tx_negative_data(tx_negative_data),
    .tx_input_clock(tx_input_clock), .line_in_a(line_in_a),
    .line_in_b(line_in_b), .line_out_pos(line_out_pos),
    .line_out_neg(line_out_neg), .seq_inject_n(seq_inject_n),
    .internal_loop_n(internal_loop_n),
    .line_out_disable_n(line_out_disable_n),
    .terminal_loop_n(terminal_loop_n), .line_loop_n(line_loop_n),
    .coder_enable_n(coder_enable_n), .rx_positive_data(rx_positive_data),
    .rx_negative_data(rx_negative_data),
    .recovered_clock_out(recovered_clock_out),
    .selftest_pass(selftest_pass), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));

  pst_test_ctl i_pst_test_ctl (.clk(ref_clk), .line_out_pos(line_out_pos),
    .line_out_neg(line_out_neg), .seq_inject_n(seq_inject_n),
    .internal_loop_n(internal_loop_n),
    .line_out_disable_n(line_out_disable_n),
    .terminal_loop_n(terminal_loop_n), .line_loop_n(line_loop_n),
    .coder_enable_n(coder_enable_n), .line_in_a(line_in_a),
    .line_in_b(line_in_b));

  // Clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Random NRZ source on the transmit pin when enabled
  always @(posedge ref_clk) begin
    if (tx_rand) begin
      tx_positive_data <= 1'($urandom_range(1, 0));
    end
  end

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t register got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string s);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %b want %b", $time, s, got, exp);
    end
  endtask

  // Cycles, then step off the edge so outputs are settled
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Bounded wait for the pass flag; cycles used end up in n
  task automatic wait_pass(input logic lvl, input int lim);
    n = 0;
    while (selftest_pass !== lvl && n < lim) begin
      cyc(1);
      n++;
    end
  endtask

  // Seen-high flags: rx negative, line pos, line neg, pass low
  task automatic watch(input int c);
    seen = 4'h0;
    repeat (c) begin
      cyc(1);
      seen = seen | {~selftest_pass, line_out_neg, line_out_pos,
                     rx_negative_data};
    end
  endtask

  // Main sequence
  initial begin
    void'($urandom(45));
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    cyc(5);
    // Reset values, access kinds, unmapped offset
    for (int a = 0; a < 16; a += 4) begin
      reg_read(4'(a), rd);
      cmp_reg(rd, 8'h00);
      reg_write(4'(a), 8'hff);
      reg_read(4'(a), rd);
      cmp_reg(rd, (a == 4) ? 8'h03 : 8'h00);
    end
    reg_write(pst_pkg::OFS_MASK, 8'h00);
    $display("registers done");
    // Generator through coder and internal loop
    i_pst_test_ctl.set_mode(6'h3c, 1'b0, 2'h0);
    wait_pass(1'b1, 4000);
    cmp_bit(selftest_pass, 1'b1, "pass");
    cmp_bit(n >= 15 * DIV, 1'b1, "early pass");
    reg_read(pst_pkg::OFS_STATE, rd);
    cmp_reg(rd, 8'h1f);
    watch(200);
    cmp_bit(seen[0], 1'b0, "rx neg");
    cmp_bit(seen[1], 1'b1, "line pos");
    cmp_bit(seen[2], 1'b1, "line neg");
    cmp_bit(seen[3], 1'b0, "pass held");
    reg_read(pst_pkg::OFS_STATUS, rd);
    cmp_reg(rd, 8'h01);
    cmp_bit(irq, 1'b0, "masked irq");
    reg_write(pst_pkg::OFS_MASK, 8'h03);
    cyc(2);
    cmp_bit(irq, 1'b1, "irq");
    reg_write(pst_pkg::OFS_STATUS, 8'h01);
    cyc(2);
    cmp_bit(irq, 1'b0, "irq clear");
    $display("internal loop done");
    // Line driver disabled
    i_pst_test_ctl.set_mode(6'h38, 1'b0, 2'h0);
    cyc(8);
    watch(200);
    cmp_bit(seen[1] | seen[2], 1'b0, "line off");
    $display("line disable done");
    // Own data instead of the sequence breaks the pattern
    tx_rand <= 1'b1;
    i_pst_test_ctl.set_mode(6'h3d, 1'b0, 2'h0);
    wait_pass(1'b0, 2000);
    cmp_bit(selftest_pass, 1'b0, "fail");
    reg_read(pst_pkg::OFS_STATUS, rd);
    cmp_reg(rd, 8'h02);
    cmp_bit(irq, 1'b1, "fall irq");
    reg_write(pst_pkg::OFS_STATUS, 8'h02);
    cyc(2);
    cmp_bit(irq, 1'b0, "fall clear");
    tx_rand <= 1'b0;
    $display("bad pattern done");
    // External capacitor loop, then a dead line
    i_pst_test_ctl.set_mode(6'h3e, 1'b1, 2'h0);
    wait_pass(1'b1, 4000);
    cmp_bit(selftest_pass, 1'b1, "ext pass");
    i_pst_test_ctl.set_mode(6'h3e, 1'b0, 2'h0);
    wait_pass(1'b0, 2000);
    cmp_bit(selftest_pass, 1'b0, "dead line");
    $display("external loop done");
    // Terminal loop with random pin values
    i_pst_test_ctl.set_mode(6'h37, 1'b0, 2'h0);
    repeat (8) begin
      v = 3'($urandom_range(7, 0));
      @(posedge ref_clk);
      {tx_input_clock, tx_negative_data, tx_positive_data} <= v;
      cyc(8);
      cmp_bit(rx_positive_data, v[0], "term p");
      cmp_bit(rx_negative_data, v[1], "term n");
      cmp_bit(recovered_clock_out, v[2], "term clk");
    end
    $display("terminal loop done");
    // Coder bypassed with negative rail held high, then enabled with it low
    @(posedge ref_clk);
    {tx_input_clock, tx_negative_data, tx_positive_data} <= 3'b010;
    i_pst_test_ctl.set_mode(6'h1d, 1'b0, 2'h0);
    cyc(60);
    cmp_bit(rx_negative_data, 1'b1, "bypass");
    @(posedge ref_clk);
    tx_negative_data <= 1'b0;
    i_pst_test_ctl.set_mode(6'h3d, 1'b0, 2'h0);
    cyc(60);
    cmp_bit(rx_negative_data, 1'b0, "coder on");
    $display("coder done");
    // Line loop off then on, line input held at a mark
    i_pst_test_ctl.set_mode(6'h1f, 1'b0, 2'h1);
    cyc(60);
    watch(60);
    cmp_bit(seen[1], 1'b0, "no loop");
    i_pst_test_ctl.set_mode(6'h0f, 1'b0, 2'h1);
    cyc(60);
    watch(60);
    cmp_bit(seen[1], 1'b1, "line loop");
    $display("line loop done");
    end_sim();
  end

  // Watchdog
  initial begin
    #400000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
